// file: logic/adc_ctrl_pkg.sv
// Summary of operation
// - first conversion after power-up flagged unstable
// - codes 0 to 7 route analog input n
// - upper codes select internal reference nodes
// - reserved channel codes give undefined results
// - one 8-bit result register, overwritten each conversion
// - divider field gives 1,2,4,8 or 16
// - source select one picks bus clock
// - reset selects crystal reference clock
// - channel code all ones powers converter off
// - control write starts 16 to 17 cycle conversion
// - continuous bit repeats, else one per write
// - done flag set on completion, cleared by write/read
package adc_ctrl_pkg;
  localparam logic [3:0] OFS_STATUS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_RESULT         = 4'h4;
  localparam logic [3:0] OFS_CLOCK_CONTROL  = 4'h8;
  localparam logic [3:0] OFS_IRQ_STATUS     = 4'hc;
  localparam logic [3:0] OFS_IRQ_MASK       = 4'h0;
  localparam logic [3:0] OFS_IRQ_MASK_REG   = 4'h1;
  localparam logic [4:0] CHAN_POWER_OFF     = 5'h1f;
  localparam logic [4:0] CHAN_REF_HIGH      = 5'h1d;
  localparam logic [4:0] CHAN_REF_LOW       = 5'h1e;
  localparam logic [4:0] CHAN_LAST_PIN      = 5'h07;
  localparam logic [4:0] CHAN_RESET         = 5'h1f;
  localparam logic [7:0] CLKCTL_RESET       = 8'h00;
  localparam int         SRC_SEL_BIT        = 4;
  localparam int         DIV_LSB            = 5;
  localparam int         CONV_CYCLES        = 16;
  localparam int         STATUS_DONE_BIT    = 7;
  localparam int         STATUS_IEN_BIT     = 6;
  localparam int         STATUS_CONT_BIT    = 5;
  localparam int         IRQ_DONE_BIT       = 0;
  localparam int         IRQ_UNSTABLE_BIT   = 1;
  localparam logic [7:0] DIV_BY_16_MINUS1   = 8'h0f;
endpackage

// file: logic/conv_clock_div.sv
`timescale 1ns/1ps
module conv_clock_div (
  input  wire logic       clock_i,
  input  wire logic       reset_n_i,
  input  wire logic       crystal_tick_i,
  input  wire logic       src_bus_i,
  input  wire logic [2:0] div_sel_i,
  output logic            conv_tick_o
);
  logic       src_tick;
  logic [3:0] cnt_r;
  logic [3:0] last_r;
  logic [3:0] limit;
  logic [3:0] cfg_r;
  assign src_tick = src_bus_i ? 1'b1 : crystal_tick_i;
  always_comb begin
    unique case (div_sel_i)
      3'b000:  limit = 4'h0;
      3'b001:  limit = 4'h1;
      3'b010:  limit = 4'h3;
      3'b011:  limit = 4'h7;
      default: limit = 4'hf;
    endcase
  end
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      cfg_r <= 4'h0;
    end else begin
      cfg_r <= {src_bus_i, div_sel_i};
    end
  end
  // restart so a ratio change never gives a short first period
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      cnt_r <= 4'h0;
    end else if (cfg_r != {src_bus_i, div_sel_i}) begin
      cnt_r <= 4'h0;
    end else if (src_tick) begin
      cnt_r <= (cnt_r >= limit) ? 4'h0 : cnt_r + 4'h1;
    end
  end
  assign last_r = limit;
  assign conv_tick_o = src_tick && (cnt_r >= last_r) && (cfg_r == {src_bus_i, div_sel_i});
endmodule // conv_clock_div

// file: logic/adc_ctrl.sv
`timescale 1ns/1ps
module adc_ctrl (
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        crystal_tick_i,
  input  wire logic        comparator_i,
  output logic [7:0]       analog_input_enable_o,
  output logic             ref_high_select_o,
  output logic             ref_low_select_o,
  output logic             converter_power_o,
  output logic [7:0]       sar_trial_o,
  output logic             sample_o,
  output logic             result_unstable_o,
  output logic             irq_o
);
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONV   = 2'b10
  } state_t;

  state_t      state_r;
  logic [4:0]  input_channel_select_r;
  logic        continuous_convert_bit_r;
  logic        completion_irq_enable_r;
  logic        conversion_done_flag_r;
  logic [7:0]  conversion_result_r;
  logic [7:0]  converter_clock_control_r;
  logic [7:0]  sar_r;
  logic [3:0]  bit_r;
  logic        first_after_off_r;
  logic [1:0]  irq_status_r;
  logic [1:0]  irq_mask_r;
  logic        conv_tick;
  logic        ctl_wr;
  logic        res_rd;
  logic        done_evt;
  logic        powered_off;
  logic        rd_pending_r;
  logic        clk_wr;
  logic [4:0]  tick_cnt_r;
  logic [4:0]  tick_gap_r;
  logic        gap_valid_r;
  logic [4:0]  exp_gap;

  // one wait state on reads so read data comes from a flip-flop
  assign avs_waitrequest = avs_read && !rd_pending_r;
  assign ctl_wr   = avs_write && avs_address == adc_ctrl_pkg::OFS_STATUS_CONTROL;
  assign res_rd   = avs_read && rd_pending_r && avs_address == adc_ctrl_pkg::OFS_RESULT;
  assign powered_off = input_channel_select_r == adc_ctrl_pkg::CHAN_POWER_OFF;
  assign clk_wr   = avs_write && avs_address == adc_ctrl_pkg::OFS_CLOCK_CONTROL;

  conv_clock_div u_div (
    .clock_i        (clock_i),
    .reset_n_i      (reset_n_i),
    .crystal_tick_i (crystal_tick_i),
    .src_bus_i      (converter_clock_control_r[adc_ctrl_pkg::SRC_SEL_BIT]),
    .div_sel_i      (converter_clock_control_r[7:5]),
    .conv_tick_o    (conv_tick)
  );

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      rd_pending_r <= 1'b0;
    end else begin
      rd_pending_r <= avs_read && !rd_pending_r;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !rd_pending_r) begin
      unique case (avs_address)
        adc_ctrl_pkg::OFS_STATUS_CONTROL:
          avs_readdata <= {24'h000000, conversion_done_flag_r, completion_irq_enable_r,
                           continuous_convert_bit_r, input_channel_select_r};
        adc_ctrl_pkg::OFS_RESULT:        avs_readdata <= {24'h000000, conversion_result_r};
        adc_ctrl_pkg::OFS_CLOCK_CONTROL: avs_readdata <= {24'h000000, converter_clock_control_r};
        adc_ctrl_pkg::OFS_IRQ_STATUS:    avs_readdata <= {30'h0, irq_status_r};
        adc_ctrl_pkg::OFS_IRQ_MASK_REG:  avs_readdata <= {30'h0, irq_mask_r};
        default:                         avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      input_channel_select_r   <= adc_ctrl_pkg::CHAN_RESET;
      continuous_convert_bit_r <= 1'b0;
      completion_irq_enable_r  <= 1'b0;
    end else if (ctl_wr) begin
      input_channel_select_r   <= avs_writedata[4:0];
      continuous_convert_bit_r <= avs_writedata[adc_ctrl_pkg::STATUS_CONT_BIT];
      completion_irq_enable_r  <= avs_writedata[adc_ctrl_pkg::STATUS_IEN_BIT];
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      converter_clock_control_r <= adc_ctrl_pkg::CLKCTL_RESET;
    end else if (clk_wr) begin
      converter_clock_control_r <= {avs_writedata[7:4], 4'h0};
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      irq_mask_r <= 2'b00;
    end else if (avs_write && avs_address == adc_ctrl_pkg::OFS_IRQ_MASK_REG) begin
      irq_mask_r <= avs_writedata[1:0];
    end
  end

  // channel decode to the analog mux
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_mux
      assign analog_input_enable_o[g] = input_channel_select_r == 5'(g);
    end
  endgenerate
  assign ref_high_select_o = input_channel_select_r == adc_ctrl_pkg::CHAN_REF_HIGH;
  assign ref_low_select_o  = input_channel_select_r == adc_ctrl_pkg::CHAN_REF_LOW;
  assign converter_power_o = !powered_off;

  // sample cycle then 8 trials of 2 ticks each gives 17 ticks
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      state_r <= ST_IDLE;
      sar_r   <= 8'h00;
      bit_r   <= 4'h0;
    end else if (ctl_wr || powered_off) begin
      state_r <= (ctl_wr && avs_writedata[4:0] != adc_ctrl_pkg::CHAN_POWER_OFF) ? ST_SAMPLE : ST_IDLE;
      sar_r   <= 8'h00;
      bit_r   <= 4'h0;
    end else if (conv_tick) begin
      unique case (state_r)
        ST_IDLE: ;
        ST_SAMPLE: begin
          state_r <= ST_CONV;
          sar_r   <= 8'h80;
          bit_r   <= 4'h0;
        end
        ST_CONV: begin
          bit_r <= bit_r + 4'h1;
          if (bit_r[0]) begin
            // trial settles one tick, decided the next
            if (!comparator_i) sar_r[3'(7 - bit_r[3:1])] <= 1'b0;
            if (bit_r[3:1] != 3'h7) sar_r[3'(6 - bit_r[3:1])] <= 1'b1;
            if (bit_r == 4'hf) begin
              state_r <= continuous_convert_bit_r ? ST_SAMPLE : ST_IDLE;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end
  assign done_evt = conv_tick && state_r == ST_CONV && bit_r == 4'hf && !ctl_wr && !powered_off;
  assign sar_trial_o = sar_r;
  assign sample_o    = state_r == ST_SAMPLE;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      conversion_result_r <= 8'h00;
    end else if (done_evt) begin
      conversion_result_r <= comparator_i ? sar_r : (sar_r & 8'hfe);
    end
  end

  // the first result after power-off is marked unstable
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      first_after_off_r <= 1'b1;
      result_unstable_o <= 1'b1;
    end else if (powered_off) begin
      first_after_off_r <= 1'b1;
    end else if (done_evt) begin
      first_after_off_r <= 1'b0;
      result_unstable_o <= first_after_off_r;
    end
  end

  // set wins over clear
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      conversion_done_flag_r <= 1'b0;
    end else if (done_evt) begin
      conversion_done_flag_r <= 1'b1;
    end else if (ctl_wr || res_rd) begin
      conversion_done_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      irq_status_r <= 2'b00;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (avs_write && avs_address == adc_ctrl_pkg::OFS_IRQ_STATUS && avs_writedata[i]) begin
          irq_status_r[i] <= 1'b0;
        end
      end
      if (done_evt && completion_irq_enable_r) irq_status_r[adc_ctrl_pkg::IRQ_DONE_BIT] <= 1'b1;
      if (done_evt && first_after_off_r) irq_status_r[adc_ctrl_pkg::IRQ_UNSTABLE_BIT] <= 1'b1;
    end
  end
  assign irq_o = |(irq_status_r & irq_mask_r);

  // ticks of the running conversion, kept apart from bit_r
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      tick_cnt_r <= 5'h00;
    end else if (ctl_wr || powered_off || done_evt) begin
      tick_cnt_r <= 5'h00;
    end else if (conv_tick && state_r != ST_IDLE) begin
      tick_cnt_r <= tick_cnt_r + 5'h01;
    end
  end

  // gap between ticks; first tick after a ratio write is not measured
  // since the divider restarts and that period runs longer than the ratio
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      tick_gap_r  <= 5'h00;
      gap_valid_r <= 1'b0;
    end else if (clk_wr) begin
      tick_gap_r  <= 5'h00;
      gap_valid_r <= 1'b0;
    end else if (conv_tick) begin
      tick_gap_r  <= 5'h00;
      gap_valid_r <= 1'b1;
    end else if (tick_gap_r != 5'h1f) begin
      tick_gap_r  <= tick_gap_r + 5'h01;
    end
  end
  assign exp_gap = converter_clock_control_r[7] ? 5'h0f : 5'((5'h01 << converter_clock_control_r[6:5]) - 5'h01);

  sequence conv_done_s;
    done_evt;
  endsequence

  sequence conv_start_s;
    ctl_wr && avs_writedata[4:0] != adc_ctrl_pkg::CHAN_POWER_OFF;
  endsequence

  sequence sample_tick_s;
    conv_tick && state_r == ST_SAMPLE && !ctl_wr && !powered_off;
  endsequence

  flag_set_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    conv_done_s |=> conversion_done_flag_r) else $error("done flag not set");
  flag_clr_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (ctl_wr && !done_evt) |=> !conversion_done_flag_r) else $error("done flag not cleared");
  result_upd_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    done_evt |=> conversion_result_r[7:1] == $past(sar_r[7:1])) else $error("result not loaded");
  start_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (ctl_wr && avs_writedata[4:0] != 5'h1f) |=> state_r == ST_SAMPLE) else $error("no start");
  single_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (done_evt && !continuous_convert_bit_r) |=> state_r == ST_IDLE) else $error("extra conversion");
  power_off_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (powered_off && !ctl_wr) |=> state_r == ST_IDLE) else $error("converting while off");
  mux_pin_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    input_channel_select_r <= adc_ctrl_pkg::CHAN_LAST_PIN |-> $onehot(analog_input_enable_o))
    else $error("pin not routed");
  src_reset_a: assert property (@(posedge clock_i)
    !reset_n_i |=> !converter_clock_control_r[adc_ctrl_pkg::SRC_SEL_BIT]) else $error("bad source reset");
  unstable_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (done_evt && first_after_off_r) |=> result_unstable_o) else $error("first result not marked");

  // the done tick itself is the seventeenth
  sample_step_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    sample_tick_s ##0 !conv_start_s |=> state_r == ST_CONV && sar_r == 8'h80 && bit_r == 4'h0)
    else $error("no first trial");
  conv_len_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    done_evt |-> tick_cnt_r == 5'(adc_ctrl_pkg::CONV_CYCLES))
    else $error("conversion length wrong");
  div_gap_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (conv_tick && gap_valid_r && converter_clock_control_r[adc_ctrl_pkg::SRC_SEL_BIT]) |-> tick_gap_r == exp_gap)
    else $error("converter clock ratio wrong");
  ref_route_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    input_channel_select_r == adc_ctrl_pkg::CHAN_REF_HIGH |-> ref_high_select_o && analog_input_enable_o == 8'h00)
    else $error("reference not routed");
  reserved_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (input_channel_select_r > adc_ctrl_pkg::CHAN_LAST_PIN && input_channel_select_r < adc_ctrl_pkg::CHAN_REF_HIGH)
    |-> !(|analog_input_enable_o) && !ref_high_select_o && !ref_low_select_o) else $error("reserved code routed");
  off_idle_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    powered_off |-> !converter_power_o && state_r == ST_IDLE)
    else $error("core powered while off");
  rd_clear_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (res_rd && !done_evt) |=> !conversion_done_flag_r)
    else $error("done flag kept after read");
  irq_set_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
    (done_evt && completion_irq_enable_r) |=> irq_status_r[adc_ctrl_pkg::IRQ_DONE_BIT])
    else $error("done event lost");
endmodule // adc_ctrl

// file: sim/conv_core_model.sv
`timescale 1ns/1ps
module conv_core_model (
  input  wire logic       clock_i,
  input  wire logic [7:0] analog_input_enable_i,
  input  wire logic       ref_high_select_i,
  input  wire logic       ref_low_select_i,
  input  wire logic       converter_power_i,
  input  wire logic [7:0] sar_trial_i,
  input  wire logic       sample_i,
  output logic            comparator_o
);
  logic [7:0] level [8];
  logic [7:0] held_r;
  logic [7:0] pick;
  logic       last_r = 1'b0;
  initial for (int i = 0; i < 8; i++) level[i] = 8'h00;
  always_comb begin
    pick = ~held_r;
    for (int i = 0; i < 8; i++) if (analog_input_enable_i[i]) pick = level[i];
    if (ref_high_select_i) pick = 8'hff;
    if (ref_low_select_i) pick = 8'h00;
  end
  always_ff @(posedge clock_i) if (sample_i) held_r <= pick;
  always_ff @(posedge clock_i) last_r <= comparator_o;
  // powered down core gives no valid decision, so it toggles
  assign comparator_o = converter_power_i ? (held_r >= sar_trial_i) : ~last_r;
endmodule // conv_core_model

// file: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        clock_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic [31:0] q;
  logic        avs_waitrequest;
  logic        crystal_tick_i = 1'b0;
  logic        comparator_i;
  logic [7:0]  analog_input_enable_o;
  logic [7:0]  sar_trial_o;
  logic        ref_high_select_o, ref_low_select_o, converter_power_o;
  logic        sample_o, result_unstable_o, irq_o;
  logic [1:0]  xc = 2'h0;
  int          err_total = 0;
  int          checks = 0;
  int          n;

  always #20 clock_i = ~clock_i;
  // crystal reference as one enable every four bus cycles
  always @(posedge clock_i) begin
    xc <= xc + 2'h1;
    crystal_tick_i <= (xc == 2'h3);
  end

  adc_ctrl dut_u (.clock_i, .reset_n_i, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .crystal_tick_i, .comparator_i, .analog_input_enable_o, .ref_high_select_o,
    .ref_low_select_o, .converter_power_o, .sar_trial_o, .sample_o, .result_unstable_o, .irq_o);
  conv_core_model core_u (.clock_i, .analog_input_enable_i(analog_input_enable_o),
    .ref_high_select_i(ref_high_select_o), .ref_low_select_i(ref_low_select_o),
    .converter_power_i(converter_power_o), .sar_trial_i(sar_trial_o), .sample_i(sample_o),
    .comparator_o(comparator_i));

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic hang;
    err_total++;
    finish_test();
  endtask

  task automatic acc(input logic wr, input logic [3:0] a, input logic [31:0] dat);
    int w;
    w = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= dat;
    @(posedge clock_i);
    while (avs_waitrequest !== 1'b0 && w < 20) begin
      @(posedge clock_i);
      w++;
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) hang();
    @(posedge clock_i);
  endtask

  task automatic poll(input logic [3:0] a, input int b);
    n = 0;
    do begin
      acc(1'b0, a, 32'h0);
      n++;
    end while (q[b] !== 1'b1 && n < 300);
    if (q[b] !== 1'b1) hang();
  endtask

  task automatic irq_time(input logic [7:0] clk_ctl, input int dv);
    acc(1'b1, 4'h8, {24'h0, clk_ctl});
    acc(1'b1, 4'hc, 32'h3);
    acc(1'b1, 4'h0, 32'h43);
    n = 0;
    while (irq_o !== 1'b1 && n < 3000) begin
      @(posedge clock_i);
      n++;
    end
    chk(32'(n >= 16 * dv - 2 && n <= 18 * dv + 4), 32'h1);
    if (irq_o !== 1'b1) hang();
  endtask

  task automatic no_sample;
    n = 0;
    repeat (100) begin
      @(posedge clock_i);
      if (sample_o === 1'b1) n++;
    end
  endtask

  initial begin
    repeat (20) @(posedge clock_i);
    reset_n_i <= 1'b1;
    @(posedge clock_i);
    acc(1'b0, 4'h8, 32'h0);
    chk(q, 32'h0);
    acc(1'b0, 4'h0, 32'h0);
    chk(q, 32'h1f);
    chk(converter_power_o, 1'b0);
    acc(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0);
    $display("test reset values done");
    acc(1'b1, 4'h8, 32'h10);
    core_u.level[5] = 8'h5a;
    acc(1'b1, 4'h0, 32'h45);
    poll(4'hc, 0);
    chk(q, 32'h3);
    chk(result_unstable_o, 1'b1);
    chk(irq_o, 1'b0);
    acc(1'b1, 4'h1, 32'h1);
    chk(irq_o, 1'b1);
    acc(1'b1, 4'hc, 32'h3);
    chk(irq_o, 1'b0);
    acc(1'b0, 4'h4, 32'h0);
    chk(q, 32'h5a);
    acc(1'b1, 4'h0, 32'h45);
    poll(4'hc, 0);
    chk(result_unstable_o, 1'b0);
    $display("test interrupt and first result done");
    for (int i = 0; i < 10; i++) begin
      if (i < 8) core_u.level[i] = 8'(8'h17 * i + 8'h09);
      acc(1'b1, 4'h0, (i < 8) ? 32'(i) : 32'(29 + i - 8));
      if (i < 8) chk(analog_input_enable_o, 8'h1 << i);
      else chk({ref_high_select_o, ref_low_select_o}, (i == 8) ? 2'h2 : 2'h1);
      chk(converter_power_o, 1'b1);
      poll(4'h0, 7);
      acc(1'b0, 4'h4, 32'h0);
      chk(q, (i < 8) ? 32'(8'h17 * i + 8'h09) : ((i == 8) ? 32'hff : 32'h0));
      acc(1'b0, 4'h0, 32'h0);
      chk(q[7], 1'b0);
    end
    acc(1'b1, 4'h0, 32'h3);
    poll(4'h0, 7);
    acc(1'b1, 4'h0, 32'h3);
    acc(1'b0, 4'h0, 32'h0);
    chk(q[7], 1'b0);
    $display("test channel decode done");
    for (int i = 0; i < 9; i++) irq_time((i < 8) ? {3'(i), 5'h10} : 8'h00, (i == 8) ? 4 : (i > 3 ? 16 : 1 << i));
    $display("test clock divide done");
    acc(1'b1, 4'h8, 32'h10);
    core_u.level[3] = 8'h11;
    acc(1'b1, 4'h0, 32'h23);
    poll(4'h0, 7);
    core_u.level[3] = 8'h22;
    n = 0;
    do begin
      acc(1'b0, 4'h4, 32'h0);
      n++;
    end while (q !== 32'h22 && n < 100);
    chk(q, 32'h22);
    if (q !== 32'h22) hang();
    acc(1'b1, 4'h0, 32'h3);
    poll(4'h0, 7);
    no_sample();
    chk(n, 0);
    acc(1'b1, 4'h0, 32'h10);
    chk({analog_input_enable_o, ref_high_select_o, ref_low_select_o, converter_power_o}, 32'h001);
    acc(1'b1, 4'h0, 32'h1f);
    chk(converter_power_o, 1'b0);
    no_sample();
    chk(n, 0);
    acc(1'b1, 4'h0, 32'h3);
    poll(4'h0, 7);
    chk(result_unstable_o, 1'b1);
    $display("test continuous and power done");
    finish_test();
  end
endmodule // tb_top
